// ### rtl/spi_port_pkg.sv
// constants and types shared by the serial slave port
package spi_port_pkg;
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BITS = 13;
   localparam logic [1:0] LEN_ONE = 2'h0;
   localparam logic [1:0] LEN_TWO = 2'h1;
   localparam logic [1:0] LEN_THREE = 2'h2;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam logic LSB_FIRST_RESET = 1'h0;
   localparam logic SDO_ACTIVE_RESET = 1'h0;
   localparam logic [4:0] BIT_CNT_RESET = 5'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [12:0] ADDR_RESET = 13'h0000;
   localparam logic [1:0] PTR_RESET = 2'h0;
   typedef enum logic [1:0] {ph_instr, ph_data, ph_dead} phase_t;
endpackage

// ### rtl/sensor_spi_slave_port.sv
// serial slave port: instruction decode, data shifting, domain crossing
//
// Contract
// - frame starts at first rising clock after select low
// - 16 instruction bits then whole data bytes
// - select tied low: first rising edge starts frame
// - first instruction bit high means read
// - length code gives one, two, three or stream
// - select high at byte boundary pauses a fixed-length transfer, later resumes
// - select high mid byte aborts the transfer
// - stream mode ends at any select rise
// - last 13 instruction bits are start address
// - address up when lsb first, down otherwise
// - bit order configurable, msb first after reset
// - msb first shifts high to low, else reversed
// - output select routes read data to pin
// - output select resets to zero
// - select pin frames the four-wire mode
`timescale 1ns/1ps
module sensor_spi_slave_port
   import spi_port_pkg::*;
(
   input wire logic clk, // system clock, 200 MHz
   input wire logic rst_n, // reset, active low; synchronous on clk, asynchronous in the sclk domain
   input wire logic sclk, // serial clock from host
   input wire logic cs_n, // chip select from host, active low
   input wire logic sdio_in, // bidirectional data pin, input side
   output logic sdio_out, // bidirectional data pin, output side
   output logic sdio_oe, // bidirectional data pin drive enable
   output logic sdo, // dedicated data-out pin
   output logic sdo_oe, // dedicated data-out drive enable
   input wire logic lsb_first, // bit order select, from config register
   input wire logic sdo_active, // read path select, from config register
   output logic wr_valid, // write byte available
   input wire logic wr_ready, // consumer takes write byte
   output logic [7:0] wr_data, // write byte
   output logic [12:0] wr_addr, // register address of write byte
   output logic rd_req, // read address request pulse
   output logic [12:0] rd_addr, // register address to read
   input wire logic rd_valid, // read byte offered
   output logic rd_ready, // read byte accepted
   input wire logic [7:0] rd_data // read byte
);

////////////////////////////////////////////////////////////////////////////
// link domain: runs on sclk; the frame decoder is reset by cs_n high

logic [4:0] bit_cnt, next_bit_cnt;
logic [15:0] instr, next_instr;
logic [7:0] shreg, next_shreg;
logic [12:0] addr, next_addr;
logic [1:0] len, next_len;
logic is_read, next_is_read;
logic [1:0] bytes_done, next_bytes_done;
phase_t phase, next_phase;
// phase as the decoder sees it: a paused transfer counts as data
phase_t cur_phase;
// set at a select rise on a byte boundary of a fixed-length transfer
logic resume;
logic [7:0] sample_byte;
logic lsb_s1, lsb_s2, act_s1, act_s2;
// byte hand-off into clk domain: toggle plus held word
logic wr_tog;
logic [7:0] wr_hold;
logic [12:0] wr_hold_addr;
// read request toggle and returned byte
logic rq_tog;
logic [12:0] rq_addr;
logic [7:0] tx_byte;
logic tx_bit;

// config bits cross into link domain through two flops
always_ff @(posedge sclk) begin
   lsb_s1 <= lsb_first;
   lsb_s2 <= lsb_s1;
   act_s1 <= sdo_active;
   act_s2 <= act_s1;
end

// shift one bit into the byte at the position set by bit order
function automatic logic [7:0] put_bit(input logic [7:0] b,
   input logic d, input logic lsb);
   if (lsb)
      put_bit = {d, b[7:1]};
   else
      put_bit = {b[6:0], d};
endfunction

// next state of the frame decoder
always_comb begin
   next_bit_cnt = bit_cnt;
   next_instr = instr;
   next_shreg = shreg;
   next_addr = addr;
   next_len = len;
   next_is_read = is_read;
   next_bytes_done = bytes_done;
   next_phase = phase;
   cur_phase = (phase == ph_instr && resume) ? ph_data : phase;
   sample_byte = put_bit(shreg, sdio_in, lsb_s2);
   if (cur_phase == ph_instr) begin
      if (lsb_s2)
         next_instr = {sdio_in, instr[15:1]};
      else
         next_instr = {instr[14:0], sdio_in};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(INSTR_BITS - 1)) begin
         next_bit_cnt = BIT_CNT_RESET;
         next_phase = ph_data;
         if (lsb_s2) begin
            next_is_read = instr[1];
            next_len = {instr[2], instr[3]};
            next_addr = {sdio_in, instr[15:4]};
         end else begin
            next_is_read = instr[14];
            next_len = instr[13:12];
            next_addr = {instr[11:0], sdio_in};
         end
      end
   end else if (cur_phase == ph_data) begin
      next_phase = ph_data;
      next_shreg = sample_byte;
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(BYTE_BITS - 1)) begin
         next_bit_cnt = BIT_CNT_RESET;
         if (lsb_s2)
            next_addr = addr + 13'h0001;
         else
            next_addr = addr - 13'h0001;
         next_bytes_done = bytes_done + 2'h1;
         // fixed lengths end after their count
         if (len != LEN_STREAM && bytes_done == len)
            next_phase = ph_dead;
         if (len == LEN_STREAM && bytes_done == 2'h3)
            next_bytes_done = 2'h3;
      end
   end
end

// frame starts on first rising edge with select low
// select tied low: same edge starts decoding
// inputs sampled on rising edge
// select high parks the decoder; the resume flag says what follows
always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
   if (cs_n || !rst_n) begin
      phase <= ph_instr;
      bit_cnt <= BIT_CNT_RESET;
   end else begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      instr <= next_instr;
      shreg <= next_shreg;
      addr <= next_addr;
      len <= next_len;
      is_read <= next_is_read;
      bytes_done <= next_phase == ph_instr ? PTR_RESET : next_bytes_done;
   end
end

// remember at each select rise whether the transfer may go on
// byte-boundary pause keeps fixed-length transfer
always_ff @(posedge cs_n or negedge rst_n) begin
   if (!rst_n)
      resume <= 1'b0;
   else
      resume <= cur_phase == ph_data && bit_cnt == BIT_CNT_RESET &&
         len != LEN_STREAM;
end

// publish completed write bytes and read requests by toggles
// toggles are cleared only by system reset, never by select, so that
// the far side never sees a false edge
always_ff @(posedge sclk or negedge rst_n) begin
   if (!rst_n) begin
      wr_tog <= 1'b0;
      rq_tog <= 1'b0;
   end else if (!cs_n) begin
      if (cur_phase == ph_data && bit_cnt == 5'(BYTE_BITS - 1) &&
          !is_read)
      begin
         wr_tog <= ~wr_tog;
         wr_hold <= sample_byte;
         wr_hold_addr <= addr;
      end
      // request next read byte at start of each data byte
      if (next_phase == ph_data && next_bit_cnt == BIT_CNT_RESET &&
          next_is_read &&
          (cur_phase == ph_instr || bit_cnt != BIT_CNT_RESET))
      begin
         rq_tog <= ~rq_tog;
         rq_addr <= next_addr;
      end
   end
end

// read data changes after falling edge
always_ff @(negedge sclk) begin
   if (cur_phase == ph_data && is_read) begin
      if (lsb_s2)
         tx_bit <= tx_byte[bit_cnt[2:0]];
      else
         tx_bit <= tx_byte[3'h7 - bit_cnt[2:0]];
   end else begin
      tx_bit <= 1'b0;
   end
end

// pin drive: combinational from link flops, enable gated by select
// read path select
// data-out inactive while select bit clear
// select frames the four-wire data out
always_comb begin
   sdio_out = tx_bit;
   sdo = tx_bit;
   sdio_oe = !cs_n && cur_phase == ph_data && is_read && !act_s2;
   sdo_oe = !cs_n && cur_phase == ph_data && is_read && act_s2;
end

////////////////////////////////////////////////////////////////////////////
// system domain: synchronise toggles, two-entry write buffer, reads

logic [2:0] wt_sync, rt_sync;
logic [7:0] buf_data [2];
logic [12:0] buf_addr [2];
logic [1:0] wptr, rptr, next_wptr, next_rptr;
logic push, pop;
logic rd_pend, next_rd_pend, next_rd_req;
logic [12:0] next_rd_addr;
logic [7:0] rd_byte, next_rd_byte;

// two flops per toggle, third flop for edge detection
always_ff @(posedge clk) begin
   if (!rst_n) begin
      wt_sync <= 3'h0;
      rt_sync <= 3'h0;
   end else begin
      wt_sync <= {wt_sync[1:0], wr_tog};
      rt_sync <= {rt_sync[1:0], rq_tog};
   end
end

// buffer pointer and read handshake next values
always_comb begin
   push = wt_sync[2] != wt_sync[1];
   pop = wr_valid && wr_ready;
   next_wptr = wptr + (push ? 2'h1 : 2'h0);
   next_rptr = rptr + (pop ? 2'h1 : 2'h0);
   next_rd_req = rt_sync[2] != rt_sync[1];
   next_rd_addr = next_rd_req ? rq_addr : rd_addr;
   next_rd_pend = rd_pend;
   next_rd_byte = rd_byte;
   if (next_rd_req)
      next_rd_pend = 1'b1;
   else if (rd_valid && rd_pend) begin
      next_rd_pend = 1'b0;
      next_rd_byte = rd_data;
   end
end

// register buffer, pointers and read state
always_ff @(posedge clk) begin
   if (!rst_n) begin
      wptr <= PTR_RESET;
      rptr <= PTR_RESET;
      rd_pend <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= ADDR_RESET;
      rd_byte <= BYTE_RESET;
      wr_valid <= 1'b0;
      wr_data <= BYTE_RESET;
      wr_addr <= ADDR_RESET;
      rd_ready <= 1'b0;
   end else begin
      if (push && (wptr - rptr) != 2'h2) begin
         buf_data[wptr[0]] <= wr_hold;
         buf_addr[wptr[0]] <= wr_hold_addr;
         wptr <= next_wptr;
      end
      rptr <= next_rptr;
      rd_pend <= next_rd_pend;
      rd_req <= next_rd_req;
      rd_addr <= next_rd_addr;
      rd_byte <= next_rd_byte;
      rd_ready <= next_rd_pend;
      wr_valid <= (wptr != next_rptr) && !pop || (wptr - rptr) == 2'h2;
      wr_data <= buf_data[next_rptr[0]];
      wr_addr <= buf_addr[next_rptr[0]];
   end
end

// read byte crosses as a held word: it settles one handshake after the
// request and stays put until the next byte's request, so the falling
// edge that launches the first bit reads it settled
assign tx_byte = rd_byte;

endmodule

// ### test/spi_port_assertions.sv
// pin-level assertions for the serial slave port
`timescale 1ns/1ps
module spi_port_assertions (
   input wire logic clk, // system clock
   input wire logic rst_n, // reset, active low
   input wire logic sclk, // serial clock
   input wire logic cs_n, // chip select, active low
   input wire logic sdio_out, // data pin drive
   input wire logic sdio_oe, // data pin enable
   input wire logic sdo_oe, // data-out enable
   input wire logic sdo_active, // read path select
   input wire logic wr_valid, // write byte valid
   input wire logic wr_ready, // write byte taken
   input wire logic [7:0] wr_data, // write byte
   input wire logic [12:0] wr_addr, // write address
   input wire logic rd_req // read request
);
   logic held; // data pin at last rising edge
   sequence stall_s;
      wr_valid && !wr_ready;
   endsequence
   // capture the data pin at each rising serial edge
   always_ff @(posedge sclk) held <= sdio_out;
   a_wr_hold: assert property (@(posedge clk) disable iff (!rst_n)
      stall_s |=> wr_valid && $stable({wr_data, wr_addr}))
      else $error("write byte changed while stalled");
   a_rst_quiet: assert property (@(posedge clk)
      !rst_n |=> !wr_valid && !rd_req) else $error("active in reset");
   a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      rd_req |=> !rd_req) else $error("read request too long");
   a_sdio_off: assert property (@(posedge clk) disable iff (!rst_n)
      sdo_active |-> !sdio_oe) else $error("data pin driven");
   a_sdo_off: assert property (@(posedge clk) disable iff (!rst_n)
      !sdo_active |-> !sdo_oe) else $error("data-out driven");
   a_cs_release: assert property (@(posedge clk) disable iff (!rst_n)
      cs_n |-> !sdio_oe && !sdo_oe) else $error("driving while idle");
   a_one_driver: assert property (@(posedge clk) disable iff (!rst_n)
      !(sdio_oe && sdo_oe)) else $error("both pins driven");
   a_fall_change: assert property (@(negedge sclk) disable iff (cs_n)
      sdio_oe |-> sdio_out == held) else $error("data moved on rise");
endmodule

// ### test/spi_host_model.sv
// behavioural serial bus master driving the slave port
`timescale 1ns/1ps
module spi_host_model (
   output logic sclk, // serial clock, low between frames
   output logic cs_n, // chip select, active low
   output logic mosi, // host drive on the data pin
   input wire logic miso, // line the host samples
   input wire logic lsb // bit order
);
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      mosi = 1'h0;
   end
   // select changes only with the clock at rest
   task automatic sel(input logic v);
      #21 cs_n = v;
      #21;
   endtask
   // clock pulse with select high, lets the slave take new settings
   task automatic tick;
      #3 sclk = 1'h1;
      #3 sclk = 1'h0;
   endtask
   // shift n bits, junk on the line when not sending
   // clock rests high after a unit so the slave can fetch read data
   task automatic shift(input logic [15:0] w, input int n, input logic own,
                        output logic [15:0] r);
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         mosi = own ? w[lsb ? i : n - 1 - i] : ~mosi;
         #3 sclk = 1'h1;
         r[lsb ? i : n - 1 - i] = miso;
         if (i == n - 1) #60;
         #3 sclk = 1'h0;
      end
   endtask
endmodule

// ### test/tb.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
   import spi_port_pkg::*;
   logic clk = 1'h0, rst_n, lsb_first = 1'h0, sdo_active = 1'h0;
   logic wr_ready = 1'h0, rd_valid = 1'h0, stall = 1'h0;
   logic [7:0] rd_data = 8'h00, wr_data;
   logic [12:0] wr_addr, rd_addr;
   logic sclk, cs_n, mosi, sdio_in, miso, sdio_out, sdio_oe, sdo, sdo_oe;
   logic wr_valid, rd_req, rd_ready;
   logic [20:0] exp_q[$], got_q[$];
   int error_cnt = 0, n_compared = 0;
   always #2.5 clk = ~clk;
   // resolve the shared data pin and the host's read line
   assign sdio_in = sdio_oe ? sdio_out : mosi;
   assign miso = sdo_active ? sdo : sdio_in;
   sensor_spi_slave_port DUT (.clk, .rst_n, .sclk, .cs_n, .sdio_in, .sdio_out,
      .sdio_oe, .sdo, .sdo_oe, .lsb_first, .sdo_active, .wr_valid, .wr_ready,
      .wr_data, .wr_addr, .rd_req, .rd_addr, .rd_valid, .rd_ready, .rd_data);
   spi_host_model host (.sclk, .cs_n, .mosi, .miso, .lsb(lsb_first));
   function automatic logic [7:0] exp_rd(logic [12:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction
   // register-side partner: stalling consumer and read data source
   always @(posedge clk) begin
      wr_ready <= !stall && ($urandom % 4 != 0);
      rd_valid <= rd_req || (rd_valid && !rd_ready);
      if (rd_req) rd_data <= exp_rd(rd_addr);
      if (wr_valid && wr_ready) got_q.push_back({wr_addr, wr_data});
   end
   task automatic frame(input logic rw, input logic [1:0] len, input int nb,
                        input int cut);
      logic [12:0] a;
      logic [15:0] r;
      logic [15:0] w;
      logic [7:0] d;
      a = 13'($urandom);
      // direction first, then length high, length low, address
      w = lsb_first ? {a, len[0], len[1], rw} : {rw, len, a};
      host.sel(1'h0);
      host.shift(w, 16, 1'h1, r);
      for (int b = 0; b < nb; b++) begin
         d = 8'($urandom);
         // pause at a byte boundary for short transfers
         if (len != LEN_STREAM && $urandom % 2) begin
            host.sel(1'h1);
            host.sel(1'h0);
         end
         host.shift({8'h00, d}, 8, !rw, r);
         if (rw) `CHK("read byte", exp_rd(a), r[7:0])
         else exp_q.push_back({a, d});
         a = lsb_first ? a + 13'h1 : a - 13'h1;
      end
      if (cut > 0) host.shift(16'h0000, cut, !rw, r);
      host.sel(1'h1);
   endtask
   task automatic settle_check;
      repeat (40) @(posedge clk);
      `CHK("write count", exp_q.size(), got_q.size())
      foreach (exp_q[i]) if (i < got_q.size())
         `CHK("write entry", exp_q[i], got_q[i])
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic print_verdict;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog against a hung transfer
   initial begin
      #100000;
      error_cnt++;
      print_verdict;
   end
   // main sequence: every direction and length code, then corners
   initial begin
      int nb;
      void'($urandom(32'h18A4));
      rst_n <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         lsb_first <= i > 7 ? 1'($urandom) : 1'h0;
         sdo_active <= i > 7 ? 1'($urandom) : 1'h0;
         @(posedge clk);
         // two idle pulses carry the new settings into the link side
         host.tick();
         host.tick();
         nb = i[2:1] == LEN_STREAM ? 4 + $urandom % 3 : i[2:1] + 1;
         frame(i[0], i[2:1], nb, 0);
         settle_check;
      end
      // abort in mid byte keeps only whole bytes
      frame(1'h0, LEN_TWO, 1, 5);
      settle_check;
      // receiver stalls: two bytes buffered, third dropped
      stall <= 1'h1;
      frame(1'h0, LEN_THREE, 3, 0);
      exp_q = exp_q[0:1];
      stall <= 1'h0;
      settle_check;
      print_verdict;
   end
endmodule
bind sensor_spi_slave_port spi_port_assertions u_chk (.clk, .rst_n, .sclk,
   .cs_n, .sdio_out, .sdio_oe, .sdo_oe, .sdo_active, .wr_valid, .wr_ready,
   .wr_data, .wr_addr, .rd_req);
